// File: common/tcr_pkg.sv
// package: register map, field layout and types for the timer channel/counter block
package tcr_pkg;
   localparam int          NUM_CHAN      = 4;
   localparam int          CNT_W         = 16;
   localparam logic [7:0]  OFS_CHAN_CTL  = 8'h20;
   localparam logic [7:0]  OFS_COUNTER   = 8'h24;
   localparam logic [7:0]  OFS_PRESCALE  = 8'h28;
   localparam logic [7:0]  OFS_RELOAD    = 8'h2C;
   localparam logic [7:0]  OFS_MODE      = 8'h30;
   localparam logic [7:0]  OFS_STATUS    = 8'h44;
   localparam int          CHAN_STRIDE   = 4;
   localparam int          POL_OFS       = 1;
   localparam int          EN_OFS        = 0;
   localparam int          MODE_STRIDE   = 2;
   localparam logic [1:0]  MODE_OUTPUT   = 2'h0;
   localparam logic [15:0] CHAN_CTL_MASK = 16'h3333;
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       valid;
   } tcr_req_t;

   typedef struct packed {
      logic [NUM_CHAN-1:0] polarity;
      logic [NUM_CHAN-1:0] enable;
      logic [NUM_CHAN-1:0] is_output;
   } tcr_chan_cfg_t;
endpackage

// File: verilog/tcr_chan.sv
// one capture/compare channel: polarity, enable and input edge detection
`timescale 1ns/1ps
module tcr_chan (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic polarity,
   input  wire logic enable,
   input  wire logic is_output,
   input  wire logic compare_active,
   input  wire logic filtered_input,
   output logic      chan_output,
   output logic      chan_output_en,
   output logic      capture_event
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic cond;
   logic out_d;
   logic out_q;

   // inverted input for polarity 1, so active edge is always a rising one
   assign cond = sync_q ^ polarity;

   always_comb begin
      if (is_output && enable) begin
         out_d = compare_active ^ polarity;
      end else begin
         out_d = polarity;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         meta_q <= filtered_input;
         sync_q <= meta_q;
         prev_q <= sync_q;
         out_q  <= out_d;
      end
   end

   assign chan_output    = out_q;
   assign chan_output_en = is_output & enable;
   assign capture_event  = !is_output && enable && cond && !(prev_q ^ polarity);
endmodule

// File: verilog/tcr_top.sv
// timer channel enable/polarity, counter, prescaler and reload with AHB-Lite slave
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module tcr_top #(
   parameter int CNT_W = tcr_pkg::CNT_W
) (
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic      [31:0]                   hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   input  wire logic [tcr_pkg::NUM_CHAN-1:0]  filtered_chan_input,
   output logic      [tcr_pkg::NUM_CHAN-1:0]  chan_output,
   output logic      [tcr_pkg::NUM_CHAN-1:0]  chan_output_en,
   output logic      [tcr_pkg::NUM_CHAN-1:0]  capture_event,
   output logic                               update_event,
   output logic                               counter_tick
);
   ////////////////////////////////////////////////////////////////////////////
   // bus request
   tcr_pkg::tcr_req_t req_d;
   tcr_pkg::tcr_req_t req_q;
   logic [31:0]       rdata_d;
   logic [31:0]       rdata_q;

   always_comb begin
      req_d = '{addr: 8'h00, write: 1'b0, valid: 1'b0};
      if (hsel && hready && htrans == tcr_pkg::HTRANS_NONSEQ
          && hsize == tcr_pkg::HSIZE_WORD) begin
         req_d.addr  = haddr[7:0];
         req_d.write = hwrite;
         req_d.valid = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0]      chan_ctl_q;
   logic [15:0]      chan_ctl_d;
   logic [7:0]       mode_q;
   logic [7:0]       mode_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] psc_q;
   logic [CNT_W-1:0] psc_d;
   logic [CNT_W-1:0] psc_shadow_q;
   logic [CNT_W-1:0] psc_shadow_d;
   logic [CNT_W-1:0] div_q;
   logic [CNT_W-1:0] div_d;
   logic [CNT_W-1:0] reload_q;
   logic [CNT_W-1:0] reload_d;
   logic             upd_d;
   logic             upd_q;
   logic             tick;
   logic             wrap;
   localparam int    NUM_CAP = tcr_pkg::NUM_CHAN;
   logic [NUM_CAP-1:0] cap_seen_q;
   logic [NUM_CAP-1:0] cap_seen_d;
   tcr_pkg::tcr_chan_cfg_t cfg;
   logic             wr_chan_ctl;
   logic             wr_mode;
   logic             wr_cnt;
   logic             wr_psc;
   logic             wr_reload;
   logic             wr_status;

   function automatic logic hit(input tcr_pkg::tcr_req_t r, input logic [7:0] ofs);
      hit = r.valid && r.write && r.addr == ofs;
   endfunction

   function automatic logic [CNT_W-1:0] incr(input logic [CNT_W-1:0] v);
      incr = CNT_W'(v + 1'b1);
   endfunction

   assign tick        = div_q == psc_shadow_q;
   assign wrap        = tick && cnt_q >= reload_q;
   assign wr_chan_ctl = hit(req_q, tcr_pkg::OFS_CHAN_CTL);
   assign wr_mode     = hit(req_q, tcr_pkg::OFS_MODE);
   assign wr_cnt      = hit(req_q, tcr_pkg::OFS_COUNTER);
   assign wr_psc      = hit(req_q, tcr_pkg::OFS_PRESCALE);
   assign wr_reload   = hit(req_q, tcr_pkg::OFS_RELOAD);
   assign wr_status   = hit(req_q, tcr_pkg::OFS_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // channel control: enable and polarity per channel, reserved bits held 0
   always_comb begin
      chan_ctl_d = chan_ctl_q;
      if (wr_chan_ctl) begin
         chan_ctl_d = hwdata[15:0] & tcr_pkg::CHAN_CTL_MASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chan_ctl_q <= 16'h0000;
      end else begin
         chan_ctl_q <= chan_ctl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode select: two bits per channel
   always_comb begin
      mode_d = mode_q;
      if (wr_mode) begin
         mode_d = hwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler register, seen by the divider only through the shadow
   always_comb begin
      psc_d = psc_q;
      if (wr_psc) begin
         psc_d = hwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         psc_q <= CNT_W'(tcr_pkg::CNT_RESET);
      end else begin
         psc_q <= psc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // auto-reload register
   always_comb begin
      reload_d = reload_q;
      if (wr_reload) begin
         reload_d = hwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reload_q <= CNT_W'(tcr_pkg::CNT_RESET);
      end else begin
         reload_q <= reload_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler shadow: loaded only on an update event
   always_comb begin
      psc_shadow_d = psc_shadow_q;
      if (wrap) begin
         psc_shadow_d = psc_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         psc_shadow_q <= CNT_W'(tcr_pkg::CNT_RESET);
      end else begin
         psc_shadow_q <= psc_shadow_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider: counts 0 to shadow, tick on the last count
   always_comb begin
      div_d = tick ? CNT_W'(tcr_pkg::CNT_RESET) : incr(div_q);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= CNT_W'(tcr_pkg::CNT_RESET);
      end else begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter: steps on tick, wraps at reload, a software write wins
   always_comb begin
      cnt_d = cnt_q;
      if (wrap) begin
         cnt_d = CNT_W'(tcr_pkg::CNT_RESET);
      end else if (tick) begin
         cnt_d = incr(cnt_q);
      end
      if (wr_cnt) begin
         cnt_d = hwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= CNT_W'(tcr_pkg::CNT_RESET);
      end else begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // update event: one pulse, a clock after the wrap
   always_comb begin
      upd_d = wrap;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         upd_q <= 1'b0;
      end else begin
         upd_q <= upd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture status: sticky, write 1 to clear, a new capture wins
   always_comb begin
      cap_seen_d = cap_seen_q | capture_event;
      if (wr_status) begin
         cap_seen_d = (cap_seen_q & ~hwdata[NUM_CAP-1:0]) | capture_event;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_seen_q <= '0;
      end else begin
         cap_seen_q <= cap_seen_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data for the next data phase

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (req_d.valid && !req_d.write) begin
         case (req_d.addr)
            tcr_pkg::OFS_CHAN_CTL: rdata_d[15:0] = chan_ctl_q;
            tcr_pkg::OFS_MODE:     rdata_d[7:0]  = mode_q;
            tcr_pkg::OFS_COUNTER:  rdata_d[CNT_W-1:0] = cnt_d;
            tcr_pkg::OFS_PRESCALE: rdata_d[CNT_W-1:0] = psc_q;
            tcr_pkg::OFS_RELOAD:   rdata_d[CNT_W-1:0] = reload_q;
            tcr_pkg::OFS_STATUS:   rdata_d[NUM_CAP-1:0] = cap_seen_q;
            default:               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= '{addr: 8'h00, write: 1'b0, valid: 1'b0};
      end else begin
         req_q <= req_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channels
   logic [NUM_CAP-1:0] cmp_active;

   always_comb begin
      for (int i = 0; i < NUM_CAP; i++) begin
         cfg.polarity[i]  = chan_ctl_q[i*tcr_pkg::CHAN_STRIDE + tcr_pkg::POL_OFS];
         cfg.enable[i]    = chan_ctl_q[i*tcr_pkg::CHAN_STRIDE + tcr_pkg::EN_OFS];
         cfg.is_output[i] = mode_q[i*tcr_pkg::MODE_STRIDE +: 2] == tcr_pkg::MODE_OUTPUT;
         cmp_active[i]    = cnt_q < (reload_q >> 1);
      end
   end

   for (genvar g = 0; g < NUM_CAP; g++) begin : g_chan
      tcr_chan u_chan (
         .mclk           (mclk),
         .rst_n          (rst_n),
         .polarity       (cfg.polarity[g]),
         .enable         (cfg.enable[g]),
         .is_output      (cfg.is_output[g]),
         .compare_active (cmp_active[g]),
         .filtered_input (filtered_chan_input[g]),
         .chan_output    (chan_output[g]),
         .chan_output_en (chan_output_en[g]),
         .capture_event  (capture_event[g])
      );
   end

   assign hrdata       = rdata_q;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign update_event = upd_q;
   assign counter_tick = tick;
endmodule

// File: verif/tcr_assertions.sv
// checker: bus answers, channel outputs and event pulses
`timescale 1ns/1ps
module tcr_assertions (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [3:0]  chan_output,
   input wire logic [3:0]  chan_output_en,
   input wire logic [3:0]  capture_event,
   input wire logic        update_event,
   input wire logic        counter_tick
);
   logic acc;
   logic wr_q;
   logic rd_q;
   assign acc = hsel && hready && htrans == tcr_pkg::HTRANS_NONSEQ;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= acc && hwrite;
         rd_q <= acc && !hwrite;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_ready; hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_idle; !rd_q |-> hrdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_cap_in; (capture_event & chan_output_en) == 4'h0; endproperty
   a_cap_in: assert property (p_cap_in) else $error("capture on output");
   property p_cap_pulse; (capture_event & $past(capture_event)) == 4'h0; endproperty
   a_cap_pulse: assert property (p_cap_pulse) else $error("capture too long");
   property p_upd_tick; update_event |-> $past(counter_tick); endproperty
   a_upd_tick: assert property (p_upd_tick) else $error("update without tick");
   property p_en_write; !$stable(chan_output_en) |-> $past(wr_q); endproperty
   a_en_write: assert property (p_en_write) else $error("enable moved alone");
   property p_idle_lvl;
      !$stable(chan_output) && chan_output_en == 4'h0 && $past(chan_output_en) == 4'h0
         |-> $past(wr_q, 2);
   endproperty
   a_idle_lvl: assert property (p_idle_lvl) else $error("idle level moved");
endmodule

// File: verif/tcr_pins.sv
// pin model: one pulse of 20 cycles on every filtered input
`timescale 1ns/1ps
module tcr_pins (
   input  wire logic       mclk,
   input  wire logic       go,
   output logic      [3:0] pins
);
   int left = 0;
   always @(posedge mclk) begin
      if (go) left <= 20;
      else if (left > 0) left <= left - 1;
   end
   assign pins = (left > 0) ? 4'hF : 4'h0;
endmodule

// File: verif/tb_tcr_top.sv
// testbench: registers, prescaler timing and channel capture
`timescale 1ns/1ps
module tb_tcr_top;
   logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic        hreadyout, hresp, update_event, counter_tick;
   logic [3:0]  pins, chan_output, chan_output_en, capture_event;
   logic [7:0]  cap [4] = '{default: 8'h00};
   logic [7:0]  ofs [5] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C};
   int          failures = 0, n_compared = 0, cyc = 0, n;
   tcr_top u_tcr_top (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .filtered_chan_input(pins), .chan_output(chan_output),
      .chan_output_en(chan_output_en), .capture_event(capture_event),
      .update_event(update_event), .counter_tick(counter_tick));
   tcr_pins u_tcr_pins (.mclk(mclk), .go(go), .pins(pins));
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++) cap[i] <= cap[i] + 8'(capture_event[i]);
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= tcr_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= tcr_pkg::HSIZE_WORD;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic gap(input logic u);
      do @(posedge mclk); while ((u ? update_event : counter_tick) !== 1'b1);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((u ? update_event : counter_tick) !== 1'b1);
   endtask
   task automatic end_sim();
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         bus(ofs[i], 1'b0, 32'h0);
         chk(rd, 32'h0);
      end
      bus(8'h20, 1'b1, 32'h3333);
      bus(8'h20, 1'b0, 32'h0);
      chk(rd, 32'h3333);
      bus(8'h20, 1'b1, 32'h0);
      bus(8'h2C, 1'b1, 32'h5);
      bus(8'h28, 1'b1, 32'h63);
      bus(8'h28, 1'b0, 32'h0);
      chk(rd, 32'h63);
      gap(1'b1);
      gap(1'b0);
      chk(n, 100);
      bus(8'h28, 1'b1, 32'h31);
      gap(1'b0);
      chk(n, 100);
      gap(1'b1);
      chk(n, 300);
      gap(1'b0);
      chk(n, 50);
      bus(8'h24, 1'b1, 32'h3);
      bus(8'h24, 1'b0, 32'h0);
      chk(rd, 32'h3);
      bus(8'h30, 1'b1, 32'h54);
      bus(8'h20, 1'b1, 32'h312);
      repeat (2) @(posedge mclk);
      chk({chan_output_en, chan_output}, 32'h05);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (10) @(posedge mclk);
      chk({cap[1], cap[2], cap[3]}, 32'h10000);
      repeat (20) @(posedge mclk);
      chk({cap[1], cap[2], cap[3]}, 32'h10100);
      bus(8'h44, 1'b0, 32'h0);
      chk(rd, 32'h6);
      bus(8'h44, 1'b1, 32'h6);
      bus(8'h44, 1'b0, 32'h0);
      chk(rd, 32'h0);
      gap(1'b0);
      bus(8'h20, 1'b1, 32'h313);
      bus(8'h24, 1'b1, 32'h0);
      repeat (2) @(posedge mclk);
      chk(chan_output_en, 32'h1);
      chk(chan_output, 32'h4);
      end_sim();
   end
endmodule
bind tcr_top tcr_assertions u_tcr_assertions (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .chan_output(chan_output),
   .chan_output_en(chan_output_en), .capture_event(capture_event),
   .update_event(update_event), .counter_tick(counter_tick));
